// [logic/overcurrent_step.sv]
// Pickup, trip and reset timing of one overcurrent step with Wishbone registers
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module overcurrent_step #(
  parameter int PROT_CYCLE_CLKS = ocstep_pkg::PROT_CYCLE_CLKS
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic [15:0] phase_current_in,
  input  wire logic [15:0] inverse_trip_delay_in,
  input  wire logic [15:0] inverse_reset_delay_in,
  input  wire logic [15:0] vr_pickup_limit_in,
  input  wire logic [15:0] vr_reset_limit_in,
  input  wire logic        harmonic_second_in,
  input  wire logic        harmonic_fifth_in,
  input  wire logic        dyn_set_one_activation_in,
  input  wire logic        dyn_set_two_activation_in,
  output logic             step_pickup_event_out,
  output logic             step_trip_event_out,
  output logic             fault_locator_start_out
);

  localparam logic [15:0] CYC_LAST = 16'(PROT_CYCLE_CLKS - 1);
  localparam logic [15:0] ONE16    = 16'h0001;
  localparam logic [15:0] ZERO16   = 16'h0000;

  logic [15:0]               cyc_cnt_q;
  logic                      tick;
  logic [ocstep_pkg::CTL_W-1:0] ctrl_q;
  ocstep_pkg::param_set_t    set_sel_q;
  logic [95:0]               set_data;
  logic [15:0]               bus_word;
  logic                      wait_q;
  logic                      ack_q;
  logic [31:0]               dat_q;
  logic                      req_first;
  logic                      set_word;
  logic                      mem_wr;
  logic                      pickup_q;
  logic                      trip_q;
  logic                      fl_start_q;
  logic [15:0]               trip_count_q;
  logic                      pur_run_q;
  logic [15:0]               pur_cnt_q;
  logic [15:0]               tr_cnt_q;
  logic [15:0]               pickup_limit;
  logic [15:0]               trip_delay;
  logic [15:0]               min_delay;
  logic [15:0]               reset_limit;
  logic [15:0]               trip_reset_mult;
  logic [15:0]               pickup_reset_delay;
  logic [15:0]               eff_pickup;
  logic [15:0]               eff_reset;
  logic [15:0]               trip_target;
  logic [15:0]               tr_delay;
  logic [31:0]               tr_product;
  logic                      reset_inverse;
  logic                      harm_block;
  logic                      over;
  logic                      below_pickup;
  logic                      below_reset;
  logic                      trip_fire;
  logic                      immediate;
  logic                      trip_release;

  ////////////////////////////////////////////////////////////////////////////////
  // Protection cycle and parameter set selection

  // Protection cycle tick generator
  always_ff @(posedge clk_in) begin
    if (reset_in || cyc_cnt_q == CYC_LAST) begin
      cyc_cnt_q <= ZERO16;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + ONE16;
    end
  end
  assign tick = (cyc_cnt_q == CYC_LAST);

  // Active set follows activating events every clock, set one first
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      set_sel_q <= ocstep_pkg::SET_STANDARD;
    end else if (dyn_set_one_activation_in) begin
      set_sel_q <= ocstep_pkg::SET_DYN_ONE;
    end else if (dyn_set_two_activation_in) begin
      set_sel_q <= ocstep_pkg::SET_DYN_TWO;
    end else begin
      set_sel_q <= ocstep_pkg::SET_STANDARD;
    end
  end

  // Three sets of six values each
  param_store u_store (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .wr_en_in      (mem_wr),
    .wr_set_in     (wb_adr_in[ocstep_pkg::ADR_SET_LO +: 2]),
    .wr_field_in   (wb_adr_in[ocstep_pkg::ADR_FLD_LO +: 3]),
    .wr_data_in    (wb_dat_in[15:0]),
    .prot_set_in   (set_sel_q),
    .prot_data_out (set_data),
    .bus_set_in    (wb_adr_in[ocstep_pkg::ADR_SET_LO +: 2]),
    .bus_field_in  (wb_adr_in[ocstep_pkg::ADR_FLD_LO +: 3]),
    .bus_data_out  (bus_word)
  );

  // Field extraction from the active set
  assign pickup_limit       = set_data[16*ocstep_pkg::FLD_PICKUP_LIMIT +: 16];
  assign trip_delay         = set_data[16*ocstep_pkg::FLD_TRIP_DELAY +: 16];
  assign min_delay          = set_data[16*ocstep_pkg::FLD_MIN_DELAY +: 16];
  assign reset_limit        = set_data[16*ocstep_pkg::FLD_RESET_LIMIT +: 16];
  assign trip_reset_mult    = set_data[16*ocstep_pkg::FLD_TRIP_RESET_DELAY +: 16];
  assign pickup_reset_delay = set_data[16*ocstep_pkg::FLD_PICKUP_RESET_DELAY +: 16];

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons and delay targets

  // Inverse reset only possible with inverse trip
  assign reset_inverse = ctrl_q[ocstep_pkg::CTL_RESET_INV]
                       & ctrl_q[ocstep_pkg::CTL_TRIP_INV];

  // Voltage restraint substitutes both limits
  assign eff_pickup = ctrl_q[ocstep_pkg::CTL_VR] ? vr_pickup_limit_in : pickup_limit;
  assign eff_reset  = ctrl_q[ocstep_pkg::CTL_VR] ? vr_reset_limit_in : reset_limit;

  // Harmonic blocking selection
  always_comb begin
    case (ocstep_pkg::harmonic_sel_t'(ctrl_q[ocstep_pkg::CTL_HARM_HI:ocstep_pkg::CTL_HARM_LO]))
      ocstep_pkg::HARM_SECOND: harm_block = harmonic_second_in;
      ocstep_pkg::HARM_FIFTH:  harm_block = harmonic_fifth_in;
      ocstep_pkg::HARM_EITHER: harm_block = harmonic_second_in | harmonic_fifth_in;
      default:                 harm_block = 1'b0;
    endcase
  end

  assign over         = (phase_current_in > eff_pickup) && !harm_block;
  assign below_pickup = (phase_current_in < eff_pickup);
  assign below_reset  = (phase_current_in < eff_reset);

  // Trip delay: inverse curve value floored at the minimum, else the fixed delay
  always_comb begin
    if (!ctrl_q[ocstep_pkg::CTL_TRIP_INV]) begin
      trip_target = trip_delay;
    end else if (inverse_trip_delay_in < min_delay) begin
      trip_target = min_delay;
    end else begin
      trip_target = inverse_trip_delay_in;
    end
  end

  // Trip reset delay, scaled curve value under inverse, saturating
  assign tr_product = 32'(inverse_reset_delay_in) * 32'(trip_reset_mult);
  always_comb begin
    if (!reset_inverse) begin
      tr_delay = trip_reset_mult;
    end else if (|tr_product[31:ocstep_pkg::MULT_SHIFT + 16]) begin
      tr_delay = 16'hffff;
    end else begin
      tr_delay = tr_product[ocstep_pkg::MULT_SHIFT +: 16];
    end
  end

  // Trip set and release conditions, evaluated per protection cycle
  assign trip_fire    = tick && pickup_q && over && (trip_count_q >= trip_target);
  assign immediate    = reset_inverse && ctrl_q[ocstep_pkg::CTL_IMMEDIATE] && below_reset;
  assign trip_release = tick && trip_q && below_pickup
                      && (immediate || tr_cnt_q >= tr_delay);

  ////////////////////////////////////////////////////////////////////////////////
  // Pickup, trip-delay counter and pickup-reset timer

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pickup_q     <= 1'b0;
      trip_count_q <= ZERO16;
      pur_run_q    <= 1'b0;
      pur_cnt_q    <= ZERO16;
    end else if (trip_release) begin
      trip_count_q <= ZERO16;
      pur_run_q    <= 1'b0;
      pur_cnt_q    <= ZERO16;
      pickup_q     <= pickup_q && !below_reset;
    end else if (tick) begin
      if (over) begin
        pickup_q  <= 1'b1;
        pur_run_q <= 1'b0;
        pur_cnt_q <= ZERO16;
        if (trip_count_q < trip_target) begin
          trip_count_q <= trip_count_q + ONE16;
        end
      end else if (pickup_q && below_pickup && below_reset) begin
        pickup_q <= 1'b0;
        if (!reset_inverse) begin
          pur_run_q <= 1'b1;
        end
      end else if (pur_run_q) begin
        if (reset_inverse) begin
          pur_run_q <= 1'b0;
          pur_cnt_q <= ZERO16;
        end else if (pur_cnt_q + ONE16 >= pickup_reset_delay) begin
          pur_run_q    <= 1'b0;
          pur_cnt_q    <= ZERO16;
          trip_count_q <= ZERO16;
        end else begin
          pur_cnt_q <= pur_cnt_q + ONE16;
        end
      end
    end
  end

  // Trip event, set wins over release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      trip_q <= 1'b0;
    end else if (trip_fire) begin
      trip_q <= 1'b1;
    end else if (trip_release) begin
      trip_q <= 1'b0;
    end
  end

  // Trip reset elapsed time while tripped and below pickup
  always_ff @(posedge clk_in) begin
    if (reset_in || !trip_q) begin
      tr_cnt_q <= ZERO16;
    end else if (tick) begin
      if (!below_pickup) begin
        tr_cnt_q <= ZERO16;
      end else if (tr_cnt_q != 16'hffff) begin
        tr_cnt_q <= tr_cnt_q + ONE16;
      end
    end
  end

  // One-cycle fault locator start on the rising trip
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fl_start_q <= 1'b0;
    end else begin
      fl_start_q <= trip_fire && !trip_q && ctrl_q[ocstep_pkg::CTL_FL_START]
                    && ctrl_q[ocstep_pkg::CTL_FL_FUNC];
    end
  end

  assign step_pickup_event_out   = pickup_q;
  assign step_trip_event_out     = trip_q;
  assign fault_locator_start_out = fl_start_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: request, wait, ack

  assign req_first = wb_cyc_in && wb_stb_in && !wait_q && !ack_q;
  assign set_word  = wb_adr_in[ocstep_pkg::ADR_SET_BIT]
                   && (wb_adr_in[ocstep_pkg::ADR_SET_LO +: 2] != 2'b11)
                   && (wb_adr_in[ocstep_pkg::ADR_FLD_LO +: 3] < ocstep_pkg::FLD_COUNT)
                   && (wb_adr_in[1:0] == 2'b00);
  assign mem_wr    = req_first && wb_we_in && set_word && (wb_sel_in[1:0] == 2'b11);

  // Two-stage answer so the store read data are ready
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wait_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      wait_q <= req_first;
      ack_q  <= wait_q;
    end
  end
  assign wb_ack_out = ack_q;

  // Control register write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= ocstep_pkg::CTL_RESET_VAL;
    end else if (req_first && wb_we_in && wb_adr_in == ocstep_pkg::ADR_CONTROL && wb_sel_in[0]) begin
      ctrl_q <= wb_dat_in[ocstep_pkg::CTL_W-1:0];
    end
  end

  // Read data capture, unmapped reads as zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dat_q <= 32'h0000_0000;
    end else if (wait_q) begin
      if (wb_adr_in == ocstep_pkg::ADR_CONTROL) begin
        dat_q <= {24'h00_0000, ctrl_q};
      end else if (wb_adr_in == ocstep_pkg::ADR_STATUS) begin
        dat_q <= {26'h000_0000, trip_q && below_pickup, pur_run_q, set_sel_q, trip_q, pickup_q};
      end else if (wb_adr_in == ocstep_pkg::ADR_TRIP_COUNT) begin
        dat_q <= {16'h0000, trip_count_q};
      end else if (set_word) begin
        dat_q <= {16'h0000, bus_word};
      end else begin
        dat_q <= 32'h0000_0000;
      end
    end
  end
  assign wb_dat_out = dat_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_PICKUP_SET: assert property (
    tick && over && !trip_release |=> pickup_q) else $error("Pickup not set above limit");

  AST_COUNT_HOLD: assert property (
    tick && pur_run_q && !over && !reset_inverse && !trip_release
    && (pur_cnt_q + ONE16 < pickup_reset_delay) |=> $stable(trip_count_q))
    else $error("Trip counter moved during pickup reset delay");

  AST_COUNT_CLEAR: assert property (
    tick && pur_run_q && !over && !reset_inverse && !(pickup_q && below_pickup && below_reset)
    && (pur_cnt_q + ONE16 >= pickup_reset_delay) |=> trip_count_q == ZERO16)
    else $error("Trip counter not cleared at pickup reset expiry");

  AST_PUR_DEFINITE_ONLY: assert property (
    tick && pickup_q && !over && below_pickup && below_reset && reset_inverse
    |=> !pur_run_q) else $error("Pickup reset timer ran under inverse reset");

  AST_PICKUP_DROP: assert property (
    tick && pickup_q && !over && below_pickup && below_reset && !trip_release
    |=> !pickup_q) else $error("Pickup stayed below both limits");

  AST_TRIP_SET: assert property (
    tick && pickup_q && over && trip_count_q >= trip_target |=> trip_q)
    else $error("Trip not asserted after delay");

  AST_HOLD_BELOW: assert property (
    tick && !over && !pur_run_q && !trip_release && !(pickup_q && below_pickup && below_reset)
    |=> $stable(trip_count_q)) else $error("Trip counter changed below pickup");

  AST_IMMEDIATE: assert property (
    tick && trip_q && !trip_fire && reset_inverse && ctrl_q[ocstep_pkg::CTL_IMMEDIATE]
    && below_reset |=> !trip_q) else $error("Immediate trip reset missed");

  AST_DEFINITE_RELEASE: assert property (
    tick && trip_q && !reset_inverse && below_pickup && tr_cnt_q >= trip_reset_mult
    |=> !trip_q) else $error("Trip not released after definite reset delay");

  AST_TRIP_HELD: assert property (
    trip_q && !reset_inverse && tr_cnt_q < tr_delay |=> trip_q)
    else $error("Trip released before reset delay elapsed");

  AST_FAULT_LOCATOR: assert property (
    fault_locator_start_out |-> $rose(trip_q) && $past(ctrl_q[ocstep_pkg::CTL_FL_FUNC]))
    else $error("Fault locator start without trip rise");

  AST_MIN_DELAY: assert property (
    ctrl_q[ocstep_pkg::CTL_TRIP_INV] && !trip_q && trip_count_q < min_delay |=> !trip_q)
    else $error("Inverse trip before minimum delay");

  AST_SET_PRIORITY: assert property (
    dyn_set_one_activation_in |=> set_sel_q == ocstep_pkg::SET_DYN_ONE)
    else $error("Dynamic set one not selected");

  AST_SET_RETURN: assert property (
    !dyn_set_one_activation_in && !dyn_set_two_activation_in
    |=> set_sel_q == ocstep_pkg::SET_STANDARD)
    else $error("Standard set not restored");

  AST_HARM_BLOCK: assert property (
    tick && harm_block && !pickup_q |=> !pickup_q) else $error("Pickup not blocked by harmonics");

  AST_INV_NEEDS_TRIP_INV: assert property (
    !ctrl_q[ocstep_pkg::CTL_TRIP_INV] && tick && pickup_q && !over
    && below_pickup && below_reset && !trip_release |=> pur_run_q)
    else $error("Definite trip did not use definite reset");

endmodule

// [logic/ocstep_pkg.sv]
// Constants, field layout and types shared by the overcurrent step timing logic
//
// Overview of operation
// - Pickup-reset delay acts only under definite reset characteristic; ignored under inverse.
// - While the pickup-reset timer runs, the trip-delay counter holds its value.
// - Pickup-reset timer expiry clears the trip-delay counter to zero.
// - Definite reset characteristic uses a fixed settable delay before trip deasserts.
// - Inverse reset delay recomputed each cycle from curve and current, scaled by multiplier.
// - Definite trip allows only definite reset; inverse trip allows either reset characteristic.
// - Trip event deasserts once the trip-reset delay has fully elapsed.
// - Inverse reset with immediate option drops trip when current falls below reset limit.
// - Pickup blocked per harmonic selection: off, second, fifth, or either harmonic.
// - Voltage-restraint option on substitutes modified pickup and reset limits.
// - Fault locator starts when option on, function enabled and trip becomes active.
// - Inverse trip never uses a delay below the programmed minimum; not for definite.
// - Standard set normally; dynamic set one or two while its activating event is active.
// - Switching between parameter sets completes within one protection cycle.
// - Each step holds its own sets of six timing and limit values.
// - Current above pickup limit asserts pickup and starts the trip-delay counter.
// - Current below pickup before trip delay stops the counter and keeps its value.
// - Trip asserts when pickup is active and the trip delay has elapsed.
// - Pickup active and current below both limits deasserts pickup, starts pickup-reset timer.
package ocstep_pkg;

  // Clock and protection cycle timing
  localparam int CLK_MHZ         = 50;
  localparam int PROT_CYCLE_US   = 1000;
  localparam int PROT_CYCLE_CLKS = PROT_CYCLE_US * CLK_MHZ;

  // Value widths and set geometry
  localparam int VAL_W      = 16;
  localparam int NUM_FIELDS = 6;
  localparam int NUM_SETS   = 3;
  localparam int WORDS      = NUM_FIELDS * NUM_SETS;
  localparam int MULT_SHIFT = 8;

  typedef enum logic [1:0] {
    SET_STANDARD = 2'b00,
    SET_DYN_ONE  = 2'b01,
    SET_DYN_TWO  = 2'b10
  } param_set_t;

  typedef enum logic [1:0] {
    HARM_OFF    = 2'b00,
    HARM_SECOND = 2'b01,
    HARM_FIFTH  = 2'b10,
    HARM_EITHER = 2'b11
  } harmonic_sel_t;

  // Field index of each value inside one parameter set
  localparam logic [2:0] FLD_PICKUP_LIMIT       = 3'h0;
  localparam logic [2:0] FLD_TRIP_DELAY         = 3'h1;
  localparam logic [2:0] FLD_MIN_DELAY          = 3'h2;
  localparam logic [2:0] FLD_RESET_LIMIT        = 3'h3;
  localparam logic [2:0] FLD_TRIP_RESET_DELAY   = 3'h4;
  localparam logic [2:0] FLD_PICKUP_RESET_DELAY = 3'h5;
  localparam logic [2:0] FLD_COUNT              = 3'h6;

  // Reset values of set words: pickup limit at full scale so nothing picks up
  localparam logic [15:0] PICKUP_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] FIELD_RESET        = 16'h0000;

  // Register byte addresses
  localparam logic [7:0] ADR_CONTROL    = 8'h00;
  localparam logic [7:0] ADR_STATUS     = 8'h04;
  localparam logic [7:0] ADR_TRIP_COUNT = 8'h08;
  localparam int         ADR_SET_BIT    = 7;
  localparam int         ADR_SET_LO     = 5;
  localparam int         ADR_FLD_LO     = 2;

  // Control register bits
  localparam int         CTL_RESET_INV = 0;
  localparam int         CTL_TRIP_INV  = 1;
  localparam int         CTL_IMMEDIATE = 2;
  localparam int         CTL_HARM_LO   = 3;
  localparam int         CTL_HARM_HI   = 4;
  localparam int         CTL_VR        = 5;
  localparam int         CTL_FL_START  = 6;
  localparam int         CTL_FL_FUNC   = 7;
  localparam int         CTL_W         = 8;
  localparam logic [7:0] CTL_RESET_VAL = 8'h00;

endpackage

// [logic/param_store.sv]
// Storage for the standard and two dynamic parameter sets of one step
`timescale 1ns/1ns
module param_store (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        wr_en_in,
  input  wire logic [1:0]  wr_set_in,
  input  wire logic [2:0]  wr_field_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic [1:0]  prot_set_in,
  output logic      [95:0] prot_data_out,
  input  wire logic [1:0]  bus_set_in,
  input  wire logic [2:0]  bus_field_in,
  output logic      [15:0] bus_data_out
);

  localparam logic [4:0] FIELDS5 = 5'(ocstep_pkg::NUM_FIELDS);

  logic [15:0] mem_q [ocstep_pkg::WORDS];
  logic [4:0]  wr_idx;
  logic [4:0]  bus_idx;
  logic [4:0]  prot_base;

  // Flat word index of set and field
  assign wr_idx    = 5'(wr_set_in) * FIELDS5 + 5'(wr_field_in);
  assign bus_idx   = 5'(bus_set_in) * FIELDS5 + 5'(bus_field_in);
  assign prot_base = 5'(prot_set_in) * FIELDS5;

  // Word writes; pickup limits reset to full scale
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < ocstep_pkg::WORDS; i++) begin
        mem_q[i] <= (i % ocstep_pkg::NUM_FIELDS == 0) ? ocstep_pkg::PICKUP_LIMIT_RESET
                                                       : ocstep_pkg::FIELD_RESET;
      end
    end else if (wr_en_in) begin
      mem_q[wr_idx] <= wr_data_in;
    end
  end

  // Registered bus read port
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bus_data_out <= ocstep_pkg::FIELD_RESET;
    end else begin
      bus_data_out <= mem_q[bus_idx];
    end
  end

  // Registered whole-set read port for the protection logic
  for (genvar f = 0; f < ocstep_pkg::NUM_FIELDS; f++) begin : g_field
    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        prot_data_out[f*16 +: 16] <= ocstep_pkg::FIELD_RESET;
      end else begin
        prot_data_out[f*16 +: 16] <= mem_q[prot_base + 5'(f)];
      end
    end
  end

endmodule

// [tb/meas_model.sv]
// Model of the current measurement channel and harmonic detector
`timescale 1ns/1ns
module meas_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] level_in,
  input  wire logic [1:0]  harm_in,
  output logic      [15:0] current_out,
  output logic             second_out,
  output logic             fifth_out
);
  // Sample the commanded level once per clock like a measurement channel
  always_ff @(posedge clk_in) begin
    current_out <= level_in;
    second_out  <= harm_in[0];
    fifth_out   <= harm_in[1];
  end
endmodule

// [tb/test_overcurrent_step.sv]
// Self-checking bench for the overcurrent step timing logic
`timescale 1ns/1ns
module test_overcurrent_step;
  logic clk_in = 1'b0, reset_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, r, rdat;
  logic ack, pu, tr, fl, h2, h5, a1 = 1'b0, a2 = 1'b0;
  logic [15:0] level = 16'h0000, cur, inv_rst = 16'h0100, inv_trip = 16'h0001;
  logic [1:0] harm = 2'b00;
  int n_fail = 0, n_tests = 0, n_fl = 0;
  always #10 clk_in = ~clk_in;
  meas_model u_meas_model (.clk_in(clk_in), .level_in(level), .harm_in(harm),
    .current_out(cur), .second_out(h2), .fifth_out(h5));
  overcurrent_step #(.PROT_CYCLE_CLKS(8)) u_overcurrent_step (.clk_in(clk_in),
    .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .phase_current_in(cur), .inverse_trip_delay_in(inv_trip),
    .inverse_reset_delay_in(inv_rst), .vr_pickup_limit_in(16'h0010),
    .vr_reset_limit_in(16'h0008), .harmonic_second_in(h2), .harmonic_fifth_in(h5),
    .dyn_set_one_activation_in(a1), .dyn_set_two_activation_in(a2),
    .step_pickup_event_out(pu), .step_trip_event_out(tr), .fault_locator_start_out(fl));
  // Count fault locator start pulses
  always @(posedge clk_in) if (fl === 1'b1) n_fl++;
  ////////////////////////////////////////////////////////////////////////////
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_in); end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0); chk(nm, e, r);
  endtask
  task automatic ticks(input int n); repeat (n * 8) @(posedge clk_in); endtask
  // Wait a bounded time for pickup (p=1) or trip (p=0) to reach level v
  task automatic wt(input bit p, input logic v, input int mx);
    int k;
    k = 0;
    while ((p ? pu : tr) !== v && k < mx) begin @(posedge clk_in); k++; end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin repeat (6000) @(posedge clk_in); n_fail++; end_of_test; end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(ocstep_pkg::ADR_CONTROL, 32'h0, "control");
    rdc(8'h80, 32'h0000ffff, "limit");
    rdc(8'h0c, 32'h0, "unmapped");
    rdc(ocstep_pkg::ADR_STATUS, 32'h0, "status");
    $display("test reset done");
    wb(1'b1, 8'h80, 32'h64); wb(1'b1, 8'h84, 32'h3); wb(1'b1, 8'h8c, 32'h50);
    wb(1'b1, 8'h90, 32'h2); wb(1'b1, 8'h94, 32'h2); wb(1'b1, 8'h00, 32'hc0);
    level <= 16'h00c8;
    wt(1, 1'b1, 24); chk("pickup", 32'h1, 32'(pu));
    level <= 16'h0000;
    ticks(1); rdc(ocstep_pkg::ADR_TRIP_COUNT, 32'h1, "count"); chk("held", 1, 32'(r != 0));
    chk("pickup drop", 32'h0, 32'(pu));
    ticks(3); rdc(ocstep_pkg::ADR_TRIP_COUNT, 32'h0, "cleared");
    $display("test hold done");
    level <= 16'h00c8; n_fl = 0;
    ticks(2); chk("early trip", 32'h0, 32'(tr));
    wt(0, 1'b1, 40); chk("trip", 32'h1, 32'(tr));
    level <= 16'h0000;
    ticks(1); chk("trip held", 32'h1, 32'(tr));
    wt(0, 1'b0, 32); chk("trip release", 32'h0, 32'(tr));
    chk("locator", 32'h1, 32'(n_fl));
    $display("test trip done");
    harm <= 2'b01;
    for (int h = 0; h < 4; h++) begin
      wb(1'b1, 8'h00, 32'(h << 3)); level <= 16'h00c8; ticks(2);
      chk("harmonic", 32'(h % 2 == 0), 32'(pu));
      level <= 16'h0000; ticks(5);
    end
    harm <= 2'b00;
    $display("test harmonic done");
    a1 <= 1'b1; a2 <= 1'b1; ticks(1); rdc(ocstep_pkg::ADR_STATUS, 32'h4, "both");
    a1 <= 1'b0; ticks(1); rdc(ocstep_pkg::ADR_STATUS, 32'h8, "dyn two");
    a2 <= 1'b0; ticks(1); rdc(ocstep_pkg::ADR_STATUS, 32'h0, "std");
    $display("test sets done");
    wb(1'b1, 8'h00, 32'h07); wb(1'b1, 8'h90, 32'h0100);
    level <= 16'h00c8; wt(0, 1'b1, 48);
    level <= 16'h0000; ticks(3); chk("immediate", 32'h0, 32'(tr));
    $display("test immediate done");
    wb(1'b1, 8'h00, 32'h20); wb(1'b1, 8'h90, 32'h0);
    level <= 16'h0020; wt(0, 1'b1, 80); chk("restrained trip", 32'h1, 32'(tr));
    level <= 16'h0000; ticks(2); chk("zero reset delay", 32'h0, 32'(tr));
    $display("test restraint done");
    wb(1'b1, 8'h00, 32'h02); wb(1'b1, 8'h88, 32'h4);
    level <= 16'h00c8; wt(1, 1'b1, 24); ticks(3);
    chk("min delay", 32'h0, 32'(tr));
    wt(0, 1'b1, 40); chk("min trip", 32'h1, 32'(tr));
    level <= 16'h0000; ticks(2);
    $display("test minimum done");
    end_of_test;
  end
endmodule
